// ==== core/spt_pkg.sv ====
// Package for the serializer port map and test control block
package spt_pkg;
  // Register addresses on the port bus
  localparam logic [9:0] SPT_ADDR_PIN_MAP0 = 10'h00F;
  localparam logic [9:0] SPT_ADDR_PIN_MAP7 = 10'h016;
  localparam logic [9:0] SPT_ADDR_TEST_EN = 10'h055;
  localparam logic [9:0] SPT_ADDR_PATTERN = 10'h00D;
  localparam int SPT_NUM_PINS = 8;
  localparam int SPT_MAP_W = 6;
  localparam int SPT_DIR_BIT = 5;
  localparam int SPT_TEST_W = 4;
  // Pattern register field positions
  localparam int SPT_PAT_EN_BIT = 6;
  localparam int SPT_PAT_HD_BIT = 5;
  localparam int SPT_PAT_PROG_BIT = 4;
  // Reset values
  localparam logic [3:0] SPT_TEST_RESET = 4'h_F;
  localparam logic [5:0] SPT_MAP_RESET = 6'h00;
  localparam logic [6:0] SPT_PAT_RESET = 7'h00;
  // Function codes for internal control bits reachable from the port
  localparam logic [4:0] SPT_FN_PAT_EN = 5'h10;
  localparam logic [4:0] SPT_FN_SCRAMB = 5'h11;
  localparam logic [4:0] SPT_FN_NRZI = 5'h12;
  localparam logic [4:0] SPT_FN_CLIP = 5'h13;
  localparam logic [4:0] SPT_FN_TRS = 5'h14;

  typedef enum logic [1:0] {
    SPT_PAT_BLACK = 2'h0,
    SPT_PAT_PLL = 2'h1,
    SPT_PAT_EQ = 2'h2,
    SPT_PAT_BARS = 2'h3
  } spt_pat_kind_t;

  // Raster standards that a pattern word selects
  typedef enum logic [3:0] {
    SPT_RS_SD_NTSC_I, SPT_RS_SD_PAL_I, SPT_RS_HD_260M_30I, SPT_RS_HD_274M_30I,
    SPT_RS_HD_274M_25I, SPT_RS_HD_295M_25I, SPT_RS_HD_274M_30P, SPT_RS_HD_274M_25P,
    SPT_RS_HD_274M_24P, SPT_RS_HD_296M_60P
  } spt_raster_t;

  typedef struct packed {
    logic scramb_en;
    logic nrzi_en;
    logic clip_en;
    logic trs_en;
  } spt_test_en_t;

  typedef struct packed {
    logic active;
    spt_raster_t raster;
    spt_pat_kind_t kind;
  } spt_pattern_t;
endpackage : spt_pkg

// ==== core/spt_port_ctrl.sv ====
// Port pin mapping, test enables and test pattern decode
`timescale 1ns/10ps
module spt_port_ctrl
  import spt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control data port
  input wire logic port_data_kind_select,
  input wire logic port_rd_wr,
  input wire logic port_strobe,
  input wire logic [9:0] port_ad_in,
  output logic [9:0] port_ad_out,
  output logic port_ad_oe,
  // Multi-function port
  input wire logic [7:0] mf_pin_in,
  output logic [7:0] mf_pin_out,
  output logic [7:0] mf_pin_oe,
  // Status bits readable through the port
  input wire logic [31:0] status_bits,
  // Processing stage data
  input wire logic [9:0] stage_data_in,
  output logic [9:0] scramb_bypass_data,
  output logic [9:0] clip_bypass_data,
  // Stage enables and pattern selection
  output spt_test_en_t test_en,
  output spt_pattern_t pattern
);

  typedef enum {ST_ADDR, ST_DATA} spt_phase_t;

  // Stage operations stand in as simple transforms; when disabled data passes unchanged
  function automatic logic [9:0] spt_scramble(input logic [9:0] d);
    spt_scramble = {d[0] ^ d[9], d[9:1]};
  endfunction : spt_scramble

  function automatic logic [9:0] spt_clip(input logic [9:0] d);
    spt_clip = (d < 10'h004) ? 10'h004 : ((d > 10'h3FB) ? 10'h3FB : d);
  endfunction : spt_clip

  function automatic logic spt_is_map(input logic [9:0] a);
    spt_is_map = (a >= SPT_ADDR_PIN_MAP0) && (a <= SPT_ADDR_PIN_MAP7);
  endfunction : spt_is_map

  spt_phase_t phase_q, phase_d;
  logic strobe_q;
  logic [9:0] addr_q;
  logic [5:0] map_q [SPT_NUM_PINS];
  logic [3:0] test_q, test_d;
  logic [6:0] pat_q, pat_d;
  logic [9:0] rd_data_q;
  logic rd_oe_q;
  logic [7:0] pin_out_q, pin_oe_q;
  logic [9:0] scr_q, clip_q;
  spt_test_en_t test_en_q;
  spt_pattern_t pattern_q;

  // Rising edge of the host strobe
  wire strobe_rise = port_strobe & ~strobe_q;
  wire ctrl_access = strobe_rise & ~port_data_kind_select;
  wire take_addr = ctrl_access & (phase_q == ST_ADDR);
  wire take_data = ctrl_access & (phase_q == ST_DATA);
  wire wr_data = take_data & ~port_rd_wr;
  wire rd_data = take_data & port_rd_wr;
  wire [2:0] map_idx = 3'(addr_q - SPT_ADDR_PIN_MAP0);
  wire map_hit = spt_is_map(addr_q);
  wire test_hit = addr_q == SPT_ADDR_TEST_EN;
  wire pat_hit = addr_q == SPT_ADDR_PATTERN;

  // Control bits that a port pin may reach by function code
  logic [31:0] fn_bits;
  always_comb begin
    fn_bits = status_bits;
    fn_bits[SPT_FN_PAT_EN] = pat_q[SPT_PAT_EN_BIT];
    fn_bits[SPT_FN_SCRAMB] = test_q[3];
    fn_bits[SPT_FN_NRZI] = test_q[2];
    fn_bits[SPT_FN_CLIP] = test_q[1];
    fn_bits[SPT_FN_TRS] = test_q[0];
  end

  // Input pins override writable control bits they are mapped to
  logic [3:0] test_pin;
  logic pat_en_pin;
  always_comb begin
    test_pin = test_q;
    pat_en_pin = pat_q[SPT_PAT_EN_BIT];
    for (int i = 0; i < SPT_NUM_PINS; i++) begin
      if (map_q[i][SPT_DIR_BIT]) begin
        case (map_q[i][4:0])
          SPT_FN_SCRAMB: test_pin[3] = mf_pin_in[i];
          SPT_FN_NRZI: test_pin[2] = mf_pin_in[i];
          SPT_FN_CLIP: test_pin[1] = mf_pin_in[i];
          SPT_FN_TRS: test_pin[0] = mf_pin_in[i];
          SPT_FN_PAT_EN: pat_en_pin = mf_pin_in[i];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      ST_ADDR: if (take_addr) phase_d = ST_DATA;
      ST_DATA: if (take_data) phase_d = ST_ADDR;
      default: phase_d = ST_ADDR;
    endcase
  end

  // Write wins; a read of the test register restores all enables
  always_comb begin
    test_d = test_pin;
    if (wr_data && test_hit) begin
      test_d = port_ad_in[3:0];
    end else if (rd_data && test_hit) begin
      test_d = SPT_TEST_RESET;
    end
  end

  always_comb begin
    pat_d = {pat_en_pin, pat_q[5:0]};
    if (wr_data && pat_hit) begin
      pat_d = port_ad_in[6:0];
    end
  end

  // Read-back value for the addressed register
  logic [9:0] rd_mux;
  always_comb begin
    rd_mux = 10'h000;
    if (map_hit) begin
      rd_mux = {4'h0, map_q[map_idx]};
    end else if (test_hit) begin
      rd_mux = {6'h00, test_q};
    end else if (pat_hit) begin
      rd_mux = {3'h0, pat_q};
    end
  end

  // Pattern decode
  spt_raster_t raster_w;
  always_comb begin
    raster_w = SPT_RS_SD_NTSC_I;
    if (!pat_q[SPT_PAT_HD_BIT]) begin
      raster_w = pat_q[SPT_PAT_PROG_BIT] ? SPT_RS_SD_PAL_I : SPT_RS_SD_NTSC_I;
    end else if (!pat_q[SPT_PAT_PROG_BIT]) begin
      case (pat_q[3:2])
        2'h0: raster_w = SPT_RS_HD_260M_30I;
        2'h1: raster_w = SPT_RS_HD_274M_30I;
        2'h2: raster_w = SPT_RS_HD_274M_25I;
        default: raster_w = SPT_RS_HD_295M_25I;
      endcase
    end else begin
      case (pat_q[3:2])
        2'h0: raster_w = SPT_RS_HD_274M_30P;
        2'h1: raster_w = SPT_RS_HD_274M_25P;
        2'h2: raster_w = SPT_RS_HD_274M_24P;
        default: raster_w = SPT_RS_HD_296M_60P;
      endcase
    end
  end

  // Output pins follow the mapped control bit
  logic [7:0] pin_out_d, pin_oe_d;
  always_comb begin
    for (int i = 0; i < SPT_NUM_PINS; i++) begin
      pin_oe_d[i] = ~map_q[i][SPT_DIR_BIT];
      pin_out_d[i] = pin_oe_d[i] & fn_bits[map_q[i][4:0]];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phase_q <= ST_ADDR;
      strobe_q <= 1'b0;
      addr_q <= 10'h000;
      test_q <= SPT_TEST_RESET;
      pat_q <= SPT_PAT_RESET;
    end else begin
      phase_q <= phase_d;
      strobe_q <= port_strobe;
      if (take_addr) addr_q <= port_ad_in;
      test_q <= test_d;
      pat_q <= pat_d;
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < SPT_NUM_PINS; i++) begin
      if (!rst_b) begin
        map_q[i] <= SPT_MAP_RESET;
      end else if (wr_data && map_hit && (map_idx == 3'(i))) begin
        map_q[i] <= port_ad_in[5:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_data_q <= 10'h000;
      rd_oe_q <= 1'b0;
      pin_out_q <= 8'h00;
      pin_oe_q <= 8'h00;
      scr_q <= 10'h000;
      clip_q <= 10'h000;
      test_en_q <= '{default: 1'b1};
      pattern_q <= '0;
    end else begin
      if (rd_data) rd_data_q <= rd_mux;
      rd_oe_q <= port_rd_wr & ~port_data_kind_select & (phase_q == ST_DATA);
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      scr_q <= test_q[3] ? spt_scramble(stage_data_in) : stage_data_in;
      clip_q <= test_q[1] ? spt_clip(stage_data_in) : stage_data_in;
      test_en_q <= '{scramb_en: test_q[3], nrzi_en: test_q[2],
                     clip_en: test_q[1], trs_en: test_q[0]};
      pattern_q <= '{active: pat_q[SPT_PAT_EN_BIT], raster: raster_w,
                     kind: pat_q[SPT_PAT_EN_BIT] ? spt_pat_kind_t'(pat_q[1:0]) : SPT_PAT_BLACK};
    end
  end

  assign port_ad_out = rd_data_q;
  assign port_ad_oe = rd_oe_q;
  assign mf_pin_out = pin_out_q;
  assign mf_pin_oe = pin_oe_q;
  assign scramb_bypass_data = scr_q;
  assign clip_bypass_data = clip_q;
  assign test_en = test_en_q;
  assign pattern = pattern_q;

endmodule : spt_port_ctrl

// ==== dv/spt_port_ctrl_sva.sv ====
// Checker for the port map and test control block
`timescale 1ns/10ps
module spt_port_ctrl_sva
  import spt_pkg::*;
(
  // Clock, reset and port
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic port_data_kind_select,
  input wire logic port_rd_wr,
  input wire logic port_strobe,
  input wire logic [9:0] port_ad_in,
  input wire logic port_ad_oe,
  // Results
  input wire logic [7:0] mf_pin_oe,
  input wire logic [9:0] stage_data_in,
  input wire logic [9:0] clip_bypass_data,
  input wire spt_test_en_t test_en,
  input wire spt_pattern_t pattern
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic stb_q, ph_q;
  logic [9:0] aq_q, wd_q;
  // Phase tracker: address edge, then data edge
  wire tk = port_strobe & ~stb_q & ~port_data_kind_select;
  wire dw = tk & ph_q & ~port_rd_wr;
  wire dr = tk & ph_q & port_rd_wr;
  always_ff @(posedge core_clk) begin
    stb_q <= rst_b & port_strobe;
    ph_q <= rst_b & (ph_q ^ tk);
    if (tk & ~ph_q) aq_q <= port_ad_in;
    if (tk & ph_q) wd_q <= port_ad_in;
  end
  sequence s_wr_test; dw && aq_q == SPT_ADDR_TEST_EN; endsequence
  sequence s_rd_test; dr && aq_q == SPT_ADDR_TEST_EN; endsequence
  sequence s_wr_pat; dw && aq_q == SPT_ADDR_PATTERN; endsequence
  a_test_bits_wr: assert property (s_wr_test |=> ##[0:1] test_en == wd_q[3:0])
    else $error("test bits not written");
  a_test_rd_restore: assert property (s_rd_test |=> ##[0:1] test_en == SPT_TEST_RESET)
    else $error("test bits not restored");
  a_wr_no_drive: assert property (dw |=> !port_ad_oe [*2])
    else $error("bus driven on write");
  a_pat_kind: assert property (s_wr_pat |=> ##[0:1] pattern.active == wd_q[6]
    && (!wd_q[6] || pattern.kind == wd_q[1:0])) else $error("pattern kind");
  a_pat_raster: assert property (s_wr_pat and port_ad_in[6] |=> ##[0:1]
    pattern.raster == (wd_q[5] ? 4'd2 + wd_q[4:2] : {3'd0, wd_q[4]})) else $error("raster");
  a_pin_dir_map: assert property (dw && aq_q >= SPT_ADDR_PIN_MAP0 && aq_q <= SPT_ADDR_PIN_MAP7
    |=> ##[0:2] mf_pin_oe[aq_q - SPT_ADDR_PIN_MAP0] == !wd_q[SPT_DIR_BIT]) else $error("pin dir");
  a_clip_pass: assert property (!test_en.clip_en && !$past(test_en.clip_en)
    |-> clip_bypass_data == $past(stage_data_in)) else $error("clip bypass");
  a_reset_dflt: assert property ($rose(rst_b) |-> test_en == SPT_TEST_RESET
    && mf_pin_oe == 8'h00 && pattern == SPT_PAT_RESET) else $error("reset values");
endmodule : spt_port_ctrl_sva
bind spt_port_ctrl spt_port_ctrl_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
  .port_data_kind_select(port_data_kind_select), .port_rd_wr(port_rd_wr),
  .port_strobe(port_strobe), .port_ad_in(port_ad_in), .port_ad_oe(port_ad_oe),
  .mf_pin_oe(mf_pin_oe), .stage_data_in(stage_data_in), .clip_bypass_data(clip_bypass_data),
  .test_en(test_en), .pattern(pattern));

// ==== dv/spt_host_model.sv ====
// Host controller model on the control data port
`timescale 1ns/10ps
module spt_host_model (
  // Clock
  input wire logic core_clk,
  // Port lines
  output logic port_data_kind_select,
  output logic port_rd_wr,
  output logic port_strobe,
  output logic [9:0] host_ad,
  // Read data
  input wire logic [9:0] port_ad_out
);
  initial begin
    port_data_kind_select = 1'b1;
    port_rd_wr = 1'b1;
    port_strobe = 1'b0;
    host_ad = 10'h000;
  end
  task automatic pulse();
    @(posedge core_clk) #1 port_strobe = 1'b1;
    @(posedge core_clk) #1 port_strobe = 1'b0;
  endtask : pulse
  task automatic xfer(input logic rd, input logic [9:0] a, input logic [9:0] d,
                      output logic [9:0] q);
    port_data_kind_select = 1'b0;
    port_rd_wr = rd;
    host_ad = a;
    pulse();
    // Released on a read, so show a changed level rather than the old word
    host_ad = rd ? ~a : d;
    pulse();
    repeat (3) @(posedge core_clk);
    #1 q = port_ad_out;
    port_data_kind_select = 1'b1;
    host_ad = ~host_ad;
    // Let one edge pass so the next transfer never re-drives select in this step
    @(posedge core_clk) #1;
  endtask : xfer
endmodule : spt_host_model

// ==== dv/spt_port_ctrl_tb_top.sv ====
// Self-checking bench for the port map and test control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module spt_port_ctrl_tb_top
  import spt_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel, rdw, stb, ad_oe;
  logic [9:0] h_ad, ad_out, sb, cb, q;
  logic [9:0] sdat = 10'h000;
  logic [7:0] pin_out, pin_oe;
  logic [7:0] pin_in = 8'h00;
  spt_test_en_t ten;
  spt_pattern_t pat;
  int n_mismatch = 0;
  int check_count = 0;
  always #50 core_clk = ~core_clk;
  spt_host_model u_host (.core_clk(core_clk), .port_data_kind_select(sel), .port_rd_wr(rdw),
    .port_strobe(stb), .host_ad(h_ad), .port_ad_out(ad_out));
  spt_port_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .port_data_kind_select(sel),
    .port_rd_wr(rdw), .port_strobe(stb), .port_ad_in(ad_oe ? ad_out : h_ad),
    .port_ad_out(ad_out), .port_ad_oe(ad_oe), .mf_pin_in(pin_in), .mf_pin_out(pin_out),
    .mf_pin_oe(pin_oe), .status_bits(32'h0000_0000), .stage_data_in(sdat),
    .scramb_bypass_data(sb), .clip_bypass_data(cb), .test_en(ten), .pattern(pat));
  task automatic wr(input logic [9:0] a, input logic [9:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    u_host.xfer(1'b1, a, 10'h000, q);
  endtask : rd
  task automatic t_test_bits();
    logic [3:0] v [3] = '{4'h0, 4'h5, 4'hA};
    `CHK("test_en", SPT_TEST_RESET, ten)
    foreach (v[i]) begin
      wr(SPT_ADDR_TEST_EN, {6'h00, v[i]});
      `CHK("test_en", v[i], ten)
      rd(SPT_ADDR_TEST_EN);
      `CHK("test_rd", v[i], q[3:0])
      `CHK("test_en", SPT_TEST_RESET, ten)
    end
  endtask : t_test_bits
  task automatic t_bypass();
    wr(SPT_ADDR_TEST_EN, 10'h000);
    sdat = 10'h2A5;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("scramb_pass", sdat, sb)
    `CHK("clip_pass", sdat, cb)
    rd(SPT_ADDR_TEST_EN);
    sdat = 10'h000;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("clip_on", 10'h004, cb)
  endtask : t_bypass
  task automatic t_pattern();
    logic [3:0] ras;
    for (int k = 0; k < 16; k++) begin
      wr(SPT_ADDR_PATTERN, {4'h1, k[3:0], k[1:0]});
      ras = k[3] ? 4'd2 + k[2:0] : {3'd0, k[2]};
      `CHK("kind", k[1:0], pat.kind)
      `CHK("raster", ras, pat.raster)
    end
    wr(SPT_ADDR_PATTERN, 10'h03F);
    `CHK("active", 1'b0, pat.active)
  endtask : t_pattern
  task automatic t_pins();
    for (int p = 0; p < 8; p++) begin
      // A control bit is sent out on an output pin only
      wr(10'(SPT_ADDR_PIN_MAP0 + p), {5'h00, SPT_FN_SCRAMB});
      `CHK("pin_oe", 1'b1, pin_oe[p])
    end
    `CHK("pin_out", 8'hFF, pin_out)
    wr(SPT_ADDR_TEST_EN, 10'h000);
    `CHK("pin_out", 8'h00, pin_out)
    rd(SPT_ADDR_PIN_MAP7);
    `CHK("map_rd", 6'h11, q[5:0])
    wr(SPT_ADDR_PIN_MAP0, 10'h020);
    `CHK("pin_oe", 1'b0, pin_oe[0])
    // An input pin mapped to a writable control bit drives that bit
    wr(SPT_ADDR_PIN_MAP0, {4'h0, 1'b1, SPT_FN_SCRAMB});
    `CHK("scramb_pin_lo", 1'b0, ten.scramb_en)
    pin_in = 8'h01;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("scramb_pin_hi", 1'b1, ten.scramb_en)
    pin_in = 8'h00;
    rd(10'h3FF);
    `CHK("unmapped", 10'h000, q)
  endtask : t_pins
  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    t_test_bits();
    t_bypass();
    t_pattern();
    t_pins();
    print_verdict();
  end
  initial begin
    #4000000;
    n_mismatch++;
    print_verdict();
  end
endmodule : spt_port_ctrl_tb_top
